// ===== logic/dsm_defines.vh
// Register offsets, field positions, reset values and timing constants
`ifndef DSM_DEFINES_VH
`define DSM_DEFINES_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define DSM_OFS_CTRL        8'h00
`define DSM_OFS_STATUS      8'h04
`define DSM_OFS_TARGET      8'h08
`define DSM_OFS_ACCEL       8'h0c
`define DSM_OFS_DECEL       8'h10
`define DSM_OFS_RAMP_DP     8'h14
`define DSM_OFS_MODE_SEL    8'h18
`define DSM_OFS_MODE_STAT   8'h1c
`define DSM_OFS_OUT_SPEED_RAMP_COMMAND    8'h20
`define DSM_OFS_CLR_OPT     8'h24
`define DSM_OFS_WARN        8'h28
`define DSM_OFS_CNT_LO      8'h2c
`define DSM_OFS_CNT_HI      8'h30
`define DSM_OFS_CONV        8'h34
`define DSM_OFS_PPU         8'h38
`define DSM_OFS_INTERVAL    8'h3c
`define DSM_OFS_CONV_DP     8'h40
`define DSM_OFS_SCAN        8'h44

// ---------------------------------------------------------------
// Control register bit positions
// ---------------------------------------------------------------
`define DSM_CTRL_RUN        0
`define DSM_CTRL_REV        1
`define DSM_CTRL_EXC        2
`define DSM_CTRL_FSTOP      3
`define DSM_CTRL_HALT       4
`define DSM_CTRL_HOLD       5
`define DSM_CTRL_CNT_EN     6
`define DSM_CTRL_CNT_CLR    7
`define DSM_CTRL_CLAIM      8

// ---------------------------------------------------------------
// Status bit positions and clear-option bits
// ---------------------------------------------------------------
`define DSM_STAT_REACHED    0
`define DSM_STAT_EXC_RDY    1
`define DSM_STAT_FSTOPPING  2
`define DSM_STAT_REV        3
`define DSM_CLR_SPEED_RAMP_COMMAND        0
`define DSM_CLR_TORQUE_COMMAND        1
`define DSM_CLR_TLIM        2

// ---------------------------------------------------------------
// Values and timing
// ---------------------------------------------------------------
`define DSM_MODE_SPEED      16'h0000
`define DSM_SPEED_RAMP_COMMAND_MAX        16'hea60
`define DSM_WARN_FIRST      8'h32
`define DSM_WARN_LAST       8'h3c
`define DSM_CLK_HZ          100000000
`define DSM_RAMP_UNIT_NS    10000000
`define DSM_CLK_NS          10
`define DSM_MS_NS           1000000
`define DSM_INTERVAL_RST    16'h03e8
`define DSM_PPU_RST         16'h0001
`define DSM_AHB_OKAY        1'b0
`define DSM_HTRANS_NONSEQ   2'b10

`endif

// ===== logic/dsm_pulse_conv.v
// Pulse-to-frequency converter over a millisecond calculation interval
`timescale 1ns/1ps
module dsm_pulse_conv #(
    parameter MS_CYCLES = 100000
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        reset,
    // Pulse event and settings
    input  wire        pulse_rise,
    input  wire [15:0] calc_interval_ms,
    input  wire [15:0] pulses_per_unit_setting,
    input  wire [15:0] result_decimal_places,
    // Result
    output reg  [31:0] converted_speed_result
);

    reg [31:0] ms_cnt_q;
    reg [15:0] int_cnt_q;
    reg [31:0] pulses_q;
    reg [63:0] scaled;
    reg [63:0] pow10;
    reg [63:0] res;
    integer    i;

    // Result = pulses * 1000 / interval / ppu * 10^dp
    always @* begin
        pow10 = 64'h1;
        for (i = 0; i < 9; i = i + 1) begin
            if (i < result_decimal_places)
                pow10 = pow10 * 64'ha;
        end
        scaled = {32'h0, pulses_q} * 64'h3e8 * pow10;
        if (calc_interval_ms == 16'h0 || pulses_per_unit_setting == 16'h0)
            res = 64'h0;
        else
            res = scaled / {48'h0, calc_interval_ms}
                  / {48'h0, pulses_per_unit_setting};
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            ms_cnt_q               <= 32'h0;
            int_cnt_q              <= 16'h0;
            pulses_q               <= 32'h0;
            converted_speed_result <= 32'h0;
        end else if (ms_cnt_q == MS_CYCLES - 1) begin
            ms_cnt_q <= 32'h0;
            if (int_cnt_q + 16'h1 >= calc_interval_ms) begin
                int_cnt_q              <= 16'h0;
                converted_speed_result <= res[31:0];
                pulses_q <= {31'h0, pulse_rise};
            end else begin
                int_cnt_q <= int_cnt_q + 16'h1;
                pulses_q  <= pulses_q + {31'h0, pulse_rise};
            end
        end else begin
            ms_cnt_q <= ms_cnt_q + 32'h1;
            pulses_q <= pulses_q + {31'h0, pulse_rise};
        end
    end

endmodule // dsm_pulse_conv

// ===== logic/dsm_top.v
// Speed-mode control, status and pulse counter behind an AHB-Lite slave
//
// Summary of operation
// - Target applied only with run and excitation
// - Direction bit clear forward, set reverse
// - Ramp time count scaled by decimal places
// - Target operand in hundredths of hertz
// - Excitation without run holds command zero
// - Run steps command to target, ramps output
// - Hold bit freezes output frequency
// - Halt decelerates, resumes on release
// - Fast stop decelerates quickest, flags stopping
// - Priority excitation, fast stop, halt, hold
// - Mode zero is speed, reported separately
// - Reached flag when output equals command with run and excitation
// - Output frequency reported 0 to 600.00 Hz
// - Three-bit pre-scan clear option
// - Clear bit reverts frequency before each scan unless target written since the last scan
// - Warning codes 50 to 60 for program faults
// - Count rising pulses one way when enabled
// - 32-bit count split over two words
// - Clear bit zeroes the count
// - Claiming input disables its terminal function
// - Conversion runs alongside counting
// - Converted speed per millisecond interval
`timescale 1ns/1ps
`include "dsm_defines.vh"
module dsm_top #(
    parameter RAMP_UNIT_CYCLES = `DSM_RAMP_UNIT_NS / `DSM_CLK_NS,
    parameter MS_CYCLES        = `DSM_MS_NS / `DSM_CLK_NS
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        reset,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Drive and pins
    input  wire        pulse_counter_input,
    input  wire        neighbour_input_terminal,
    input  wire [3:0]  program_fault,
    output reg  [15:0] drive_speed_ramp_command_cmd,
    output reg         drive_reverse,
    output reg         drive_energize,
    output reg         neighbour_terminal_out
);

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    reg        run_request_bit_q;
    reg        reverse_direction_bit_q;
    reg        excitation_request_bit_q;
    reg        fast_stop_bit_q;
    reg        halt_bit_q;
    reg        hold_frequency_bit_q;
    reg        counter_enable_bit_q;
    reg        counter_clear_bit_q;
    reg        claim_q;
    reg [15:0] target_q;
    reg        target_wr_q;
    reg [15:0] accel_q;
    reg [15:0] decel_q;
    reg [15:0] ramp_dp_q;
    reg [15:0] control_mode_select_q;
    reg [2:0]  clr_opt_q;
    reg [7:0]  warn_q;
    reg [15:0] ppu_q;
    reg [15:0] interval_q;
    reg [15:0] conv_dp_q;
    reg [15:0] out_speed_ramp_command_q;
    reg [15:0] cmd_q;
    reg [31:0] count_q;
    reg [31:0] tick_q;
    reg [31:0] step_q;
    reg        addr_ok_q;
    reg        wr_q;
    reg [7:0]  addr_q;
    reg        pin_s1_q;
    reg        pin_s2_q;
    reg        pin_s3_q;
    reg        nb_s1_q;
    reg        nb_s2_q;
    wire       pulse_rise;
    wire [31:0] conv_res;
    reg [15:0] eff_target;
    reg [15:0] ramp_time;
    reg [31:0] ramp_cycles;
    reg [15:0] speed_ramp_command_goal;
    reg [31:0] rdata_d;
    integer    k;

    // ---------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ---------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (reset) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
            nb_s1_q  <= 1'b0;
            nb_s2_q  <= 1'b0;
        end else begin
            pin_s1_q <= pulse_counter_input;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            nb_s1_q  <= neighbour_input_terminal;
            nb_s2_q  <= nb_s1_q;
        end
    end
    assign pulse_rise = pin_s2_q & ~pin_s3_q;

    // ---------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ---------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (reset) begin
            addr_ok_q <= 1'b0;
            wr_q      <= 1'b0;
            addr_q    <= 8'h0;
        end else if (hready) begin
            addr_ok_q <= hsel & htrans[1];
            wr_q      <= hsel & htrans[1] & hwrite;
            addr_q    <= haddr[7:0];
        end
    end

    always @* begin
        rdata_d = 32'h0;
        case (haddr[7:0])
            `DSM_OFS_CTRL:      rdata_d = {23'h0, claim_q,
                                    counter_clear_bit_q, counter_enable_bit_q,
                                    hold_frequency_bit_q, halt_bit_q,
                                    fast_stop_bit_q, excitation_request_bit_q,
                                    reverse_direction_bit_q, run_request_bit_q};
            `DSM_OFS_STATUS:    rdata_d = {28'h0, drive_reverse,
                                    fast_stop_bit_q, drive_energize,
                                    run_request_bit_q & drive_energize &
                                    (out_speed_ramp_command_q == cmd_q)};
            `DSM_OFS_TARGET:    rdata_d = {16'h0, target_q};
            `DSM_OFS_ACCEL:     rdata_d = {16'h0, accel_q};
            `DSM_OFS_DECEL:     rdata_d = {16'h0, decel_q};
            `DSM_OFS_RAMP_DP:   rdata_d = {16'h0, ramp_dp_q};
            `DSM_OFS_MODE_SEL:  rdata_d = {16'h0, control_mode_select_q};
            `DSM_OFS_MODE_STAT: rdata_d = {16'h0, `DSM_MODE_SPEED};
            `DSM_OFS_OUT_SPEED_RAMP_COMMAND:  rdata_d = {16'h0, out_speed_ramp_command_q};
            `DSM_OFS_CLR_OPT:   rdata_d = {29'h0, clr_opt_q};
            `DSM_OFS_WARN:      rdata_d = {24'h0, warn_q};
            `DSM_OFS_CNT_LO:    rdata_d = {16'h0, count_q[15:0]};
            `DSM_OFS_CNT_HI:    rdata_d = {16'h0, count_q[31:16]};
            `DSM_OFS_CONV:      rdata_d = conv_res;
            `DSM_OFS_PPU:       rdata_d = {16'h0, ppu_q};
            `DSM_OFS_INTERVAL:  rdata_d = {16'h0, interval_q};
            `DSM_OFS_CONV_DP:   rdata_d = {16'h0, conv_dp_q};
            default:            rdata_d = 32'h0;
        endcase
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= `DSM_AHB_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= `DSM_AHB_OKAY;
            if (hready && hsel && htrans[1] && !hwrite)
                hrdata <= rdata_d;
        end
    end

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (reset) begin
            run_request_bit_q        <= 1'b0;
            reverse_direction_bit_q  <= 1'b0;
            excitation_request_bit_q <= 1'b0;
            fast_stop_bit_q          <= 1'b0;
            halt_bit_q               <= 1'b0;
            hold_frequency_bit_q     <= 1'b0;
            counter_enable_bit_q     <= 1'b0;
            counter_clear_bit_q      <= 1'b0;
            claim_q                  <= 1'b0;
            target_q                 <= 16'h0;
            target_wr_q              <= 1'b0;
            accel_q                  <= 16'h0;
            decel_q                  <= 16'h0;
            ramp_dp_q                <= 16'h0;
            control_mode_select_q    <= `DSM_MODE_SPEED;
            clr_opt_q                <= 3'h0;
            ppu_q                    <= `DSM_PPU_RST;
            interval_q               <= `DSM_INTERVAL_RST;
            conv_dp_q                <= 16'h0;
        end else begin
            if (wr_q && addr_q == `DSM_OFS_SCAN) begin
                // Scan start: revert frequency unless commanded
                if (clr_opt_q[`DSM_CLR_SPEED_RAMP_COMMAND] && !target_wr_q)
                    target_q <= 16'h0;
                target_wr_q <= 1'b0;
            end
            if (wr_q) begin
                case (addr_q)
                    `DSM_OFS_CTRL: begin
                        run_request_bit_q        <= hwdata[`DSM_CTRL_RUN];
                        reverse_direction_bit_q  <= hwdata[`DSM_CTRL_REV];
                        excitation_request_bit_q <= hwdata[`DSM_CTRL_EXC];
                        fast_stop_bit_q          <= hwdata[`DSM_CTRL_FSTOP];
                        halt_bit_q               <= hwdata[`DSM_CTRL_HALT];
                        hold_frequency_bit_q     <= hwdata[`DSM_CTRL_HOLD];
                        counter_enable_bit_q     <= hwdata[`DSM_CTRL_CNT_EN];
                        counter_clear_bit_q      <= hwdata[`DSM_CTRL_CNT_CLR];
                        claim_q                  <= hwdata[`DSM_CTRL_CLAIM];
                    end
                    `DSM_OFS_TARGET: begin
                        target_q    <= hwdata[15:0];
                        target_wr_q <= 1'b1;
                    end
                    `DSM_OFS_ACCEL:    accel_q    <= hwdata[15:0];
                    `DSM_OFS_DECEL:    decel_q    <= hwdata[15:0];
                    `DSM_OFS_RAMP_DP:  ramp_dp_q  <= hwdata[15:0];
                    `DSM_OFS_MODE_SEL: control_mode_select_q <= hwdata[15:0];
                    `DSM_OFS_CLR_OPT:  clr_opt_q  <= hwdata[2:0];
                    `DSM_OFS_PPU:      ppu_q      <= hwdata[15:0];
                    `DSM_OFS_INTERVAL: interval_q <= hwdata[15:0];
                    `DSM_OFS_CONV_DP:  conv_dp_q  <= hwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Speed loop: command, priority and ramp
    // ---------------------------------------------------------------
    always @* begin
        eff_target = (target_q > `DSM_SPEED_RAMP_COMMAND_MAX) ? `DSM_SPEED_RAMP_COMMAND_MAX : target_q;
        speed_ramp_command_goal  = cmd_q;
        ramp_time  = decel_q;
        if (!excitation_request_bit_q) begin
            speed_ramp_command_goal = 16'h0;
            ramp_time = 16'h0;
        end else if (fast_stop_bit_q) begin
            speed_ramp_command_goal = 16'h0;
            ramp_time = 16'h0;
        end else if (halt_bit_q) begin
            speed_ramp_command_goal = 16'h0;
        end else if (hold_frequency_bit_q) begin
            speed_ramp_command_goal = out_speed_ramp_command_q;
        end else if (out_speed_ramp_command_q < cmd_q) begin
            ramp_time = accel_q;
        end
        // One count is 0.01 s divided by 10^dp
        ramp_cycles = {16'h0, ramp_time} * RAMP_UNIT_CYCLES;
        for (k = 0; k < 4; k = k + 1) begin
            if (k < ramp_dp_q)
                ramp_cycles = ramp_cycles / 32'ha;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            cmd_q          <= 16'h0;
            out_speed_ramp_command_q     <= 16'h0;
            tick_q         <= 32'h0;
            step_q         <= 32'h0;
            drive_speed_ramp_command_cmd <= 16'h0;
            drive_reverse  <= 1'b0;
            drive_energize <= 1'b0;
        end else begin
            // Command follows target only with run and excitation
            if (run_request_bit_q && excitation_request_bit_q)
                cmd_q <= eff_target;
            else
                cmd_q <= 16'h0;
            // Step rate: full scale over ramp time
            step_q <= ramp_cycles / {16'h0, `DSM_SPEED_RAMP_COMMAND_MAX};
            if (speed_ramp_command_goal == out_speed_ramp_command_q || ramp_time == 16'h0) begin
                out_speed_ramp_command_q <= speed_ramp_command_goal;
                tick_q     <= 32'h0;
            end else if (tick_q + 32'h1 >= step_q) begin
                tick_q <= 32'h0;
                if (out_speed_ramp_command_q < speed_ramp_command_goal)
                    out_speed_ramp_command_q <= out_speed_ramp_command_q + 16'h1;
                else
                    out_speed_ramp_command_q <= out_speed_ramp_command_q - 16'h1;
            end else begin
                tick_q <= tick_q + 32'h1;
            end
            drive_speed_ramp_command_cmd <= out_speed_ramp_command_q;
            drive_reverse  <= reverse_direction_bit_q;
            drive_energize <= excitation_request_bit_q;
        end
    end

    // ---------------------------------------------------------------
    // Warnings, pulse counter and terminal claim
    // ---------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (reset) begin
            warn_q                 <= 8'h0;
            count_q                <= 32'h0;
            neighbour_terminal_out <= 1'b0;
        end else begin
            // Fault index 1..11 maps to codes 50..60
            if (program_fault != 4'h0 && program_fault <= 4'hb)
                warn_q <= `DSM_WARN_FIRST + {4'h0, program_fault}
                          - 8'h1;
            else if (wr_q && addr_q == `DSM_OFS_WARN)
                warn_q <= 8'h0;
            if (counter_clear_bit_q)
                count_q <= 32'h0;
            else if (counter_enable_bit_q && pulse_rise)
                count_q <= count_q + 32'h1;
            neighbour_terminal_out <= claim_q ? 1'b0 : nb_s2_q;
        end
    end

    // Converter shares the edge stream but keeps its own count
    dsm_pulse_conv #(
        .MS_CYCLES (MS_CYCLES)
    ) u_conv (
        .clk_sys                 (clk_sys),
        .reset                   (reset),
        .pulse_rise              (pulse_rise),
        .calc_interval_ms        (interval_q),
        .pulses_per_unit_setting (ppu_q),
        .result_decimal_places   (conv_dp_q),
        .converted_speed_result  (conv_res)
    );

endmodule // dsm_top

// ===== verification/dsm_pulse_src.sv
// Pulse source standing in for the sensor on the counter input
`timescale 1ns/1ps
module dsm_pulse_src #(
    parameter PERIOD = 10
) (
    // Clock
    input  wire        clk_sys,
    // Burst request
    input  wire        start,
    input  wire [15:0] n_pulses,
    // Pin and state
    output logic       pulse_out,
    output logic       busy
);
    int left_q;
    int ph_q;

    initial begin
        pulse_out = 1'b0;
        busy = 1'b0;
    end

    // Low outside bursts, one rising edge per period inside
    always @(posedge clk_sys) begin
        if (start && !busy) begin
            left_q <= n_pulses;
            ph_q <= 0;
            busy <= (n_pulses != 16'h0000);
        end else if (busy) begin
            pulse_out <= (ph_q < PERIOD / 2);
            ph_q <= (ph_q == PERIOD - 1) ? 0 : ph_q + 1;
            if (ph_q == PERIOD - 1) begin
                left_q <= left_q - 1;
                busy <= (left_q > 1);
            end
        end
    end
endmodule // dsm_pulse_src

// ===== verification/dsm_top_checker.sv
// Port-level concurrent checks for the speed-mode control block
`timescale 1ns/1ps
module dsm_top_checker (
    // Clock and reset
    input wire        clk_sys,
    input wire        reset,
    // Bus
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    // Drive and pins
    input wire [15:0] drive_speed_ramp_command_cmd,
    input wire        drive_reverse,
    input wire        drive_energize,
    input wire        neighbour_terminal_out
);
    // ----
    // Shadow of control and target writes
    // ----
    logic        wr_q;
    logic [7:0]  wa_q;
    logic [8:0]  ctl_q;
    logic [15:0] tgt_q;
    wire         run_ok = ctl_q[0] & ctl_q[2] & ~ctl_q[5];
    wire         hold_ok = ctl_q[5] & ctl_q[2]
                           & ~ctl_q[3] & ~ctl_q[4];

    always @(posedge clk_sys) begin
        if (reset) begin
            wr_q <= 1'b0;
            ctl_q <= 9'h000;
            tgt_q <= 16'h0000;
        end else if (hready) begin
            wr_q <= hsel & htrans[1] & hwrite;
            wa_q <= haddr[7:0];
            if (wr_q && wa_q == 8'h00)
                ctl_q <= hwdata[8:0];
            if (wr_q && wa_q == 8'h08)
                tgt_q <= hwdata[15:0];
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    AST_EXC_OFF_ZERO: assert property (
        !ctl_q[2] [*3] |-> drive_speed_ramp_command_cmd == 16'h0000)
        else $error("frequency without excitation");
    AST_ENERGIZE_ON: assert property (
        ctl_q[2] [*2] |-> drive_energize)
        else $error("excitation not applied");
    AST_ENERGIZE_OFF: assert property (
        !ctl_q[2] [*2] |-> !drive_energize)
        else $error("excitation not removed");
    AST_DIRECTION: assert property (
        $stable(ctl_q[1]) [*2] |-> drive_reverse == ctl_q[1])
        else $error("direction differs from request");
    AST_FAST_STOP: assert property (
        ctl_q[3] [*3] |-> drive_speed_ramp_command_cmd == 16'h0000)
        else $error("fast stop left frequency");
    AST_SPEED_RAMP_COMMAND_RANGE: assert property (drive_speed_ramp_command_cmd <= 16'hea60)
        else $error("output frequency above ceiling");
    AST_HOLD: assert property (
        hold_ok [*3] |-> $stable(drive_speed_ramp_command_cmd))
        else $error("held frequency moved");
    AST_CLAIM: assert property (
        ctl_q[8] [*2] |-> !neighbour_terminal_out)
        else $error("claimed terminal still passes");
    AST_NO_OVERSHOOT: assert property (
        $past(run_ok) && run_ok && $stable(tgt_q)
        && $past(drive_speed_ramp_command_cmd) <= tgt_q |-> drive_speed_ramp_command_cmd <= tgt_q)
        else $error("ramp passed the target");
endmodule // dsm_top_checker

bind dsm_top dsm_top_checker i_dsm_top_checker (
    .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp),
    .drive_speed_ramp_command_cmd(drive_speed_ramp_command_cmd), .drive_reverse(drive_reverse),
    .drive_energize(drive_energize),
    .neighbour_terminal_out(neighbour_terminal_out)
);

// ===== verification/test_dsm_top.sv
// Self-checking bench for the speed-mode control block
`timescale 1ns/1ps
module test_dsm_top;
    // ----
    // Signals
    // ----
    logic        clk_sys, reset, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, tgt;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        pls, nbr_in, rev, energize, nbr_out, start, busy, rd_q;
    logic [3:0]  fault;
    logic [15:0] speed_ramp_command, n_pulses;
    logic [31:0] exp_q[$];
    int          error_cnt, n_checks, seed, k;

    dsm_top #(.RAMP_UNIT_CYCLES(10), .MS_CYCLES(10)) i_dsm_top (
        .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pulse_counter_input(pls),
        .neighbour_input_terminal(nbr_in), .program_fault(fault),
        .drive_speed_ramp_command_cmd(speed_ramp_command), .drive_reverse(rev),
        .drive_energize(energize), .neighbour_terminal_out(nbr_out));

    dsm_pulse_src #(.PERIOD(10)) i_dsm_pulse_src (.clk_sys(clk_sys),
        .start(start), .n_pulses(n_pulses), .pulse_out(pls), .busy(busy));

    // ----
    // Tasks
    // ----
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic end_of_test;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ----
    // Clock, monitor and watchdog
    // ----
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (rd_q && hreadyout === 1'b1)
            cmp(hrdata, exp_q.pop_front());
        rd_q <= hsel && htrans[1] && hreadyout && !hwrite && !reset;
    end

    initial begin
        #200000;
        error_cnt++;
        end_of_test;
    end

    // ----
    // Main sequence
    // ----
    initial begin
        seed = 32'hf82f4417;
        {reset, hsel, hsize} = 5'b11010;
        {haddr, hwdata, htrans, hwrite, rd_q} = '0;
        {nbr_in, fault, start, n_pulses} = '0;
        error_cnt = 0;
        n_checks = 0;
        cyc(4);
        reset <= 1'b0;
        rd(8'h18, 0);
        rd(8'h1c, 0);
        rd(8'h20, 0);
        rd(8'h3c, 32'h3e8);
        wr(8'h80, 32'hffffffff);
        rd(8'h80, 0);
        // Excitation, direction, then run with a random target
        tgt = $unsigned($random(seed)) % 32'd3000;
        wr(8'h08, tgt);
        wr(8'h00, 32'h6);
        cyc(4);
        rd(8'h20, 0);
        rd(8'h04, 32'ha);
        cmp({31'h0, rev}, 32'h1);
        wr(8'h00, 32'h5);
        cyc(4);
        rd(8'h20, tgt);
        rd(8'h04, 32'h3);
        // Hold against a new target, one cycle a step at one decimal
        wr(8'h0c, 60000);
        wr(8'h14, 1);
        wr(8'h00, 32'h25);
        wr(8'h08, tgt + 1000);
        cyc(50);
        rd(8'h20, tgt);
        wr(8'h00, 32'h5);
        cyc(20);
        cmp({31'h0, speed_ramp_command < tgt + 1000}, 32'h1);
        cyc(1100);
        rd(8'h20, tgt + 1000);
        wr(8'h00, 32'h15);
        cyc(4);
        rd(8'h20, 0);
        wr(8'h00, 32'h5);
        cyc(4100);
        rd(8'h20, tgt + 1000);
        wr(8'h00, 32'h1d);
        cyc(4);
        rd(8'h20, 0);
        wr(8'h08, 0);
        cyc(1);
        rd(8'h04, 32'h7);
        // Run cleared ramps down at ten cycles a step
        wr(8'h08, 1000);
        wr(8'h00, 32'h5);
        cyc(1100);
        wr(8'h14, 0);
        wr(8'h10, 60000);
        wr(8'h00, 32'h4);
        cyc(20);
        cmp({31'h0, speed_ramp_command != 16'h0}, 32'h1);
        wr(8'h00, 0);
        cyc(4);
        rd(8'h20, 0);
        wr(8'h0c, 0);
        wr(8'h10, 0);
        for (k = 0; k < 2; k++) begin
            wr(8'h24, k ? 6 : 7);
            rd(8'h24, k ? 6 : 7);
            wr(8'h08, 500);
            wr(8'h44, 0);
            wr(8'h44, 0);
            wr(8'h00, 32'h5);
            cyc(4);
            rd(8'h20, k ? 500 : 0);
            wr(8'h00, 0);
        end
        for (k = 1; k <= 11; k++) begin
            fault <= k[3:0];
            cyc(3);
            fault <= 4'h0;
            rd(8'h28, 32'd49 + k);
            wr(8'h28, 0);
        end
        // Counting and conversion side by side
        nbr_in <= 1'b1;
        cyc(4);
        cmp({31'h0, nbr_out}, 32'h1);
        wr(8'h38, 5);
        wr(8'h3c, 10);
        wr(8'h40, 2);
        wr(8'h00, 32'h140);
        cyc(3);
        cmp({31'h0, nbr_out}, 32'h0);
        n_pulses <= 16'd40;
        start <= 1'b1;
        cyc(1);
        start <= 1'b0;
        cyc(300);
        rd(8'h34, 20000);
        while (busy)
            cyc(1);
        cyc(5);
        rd(8'h2c, 40);
        rd(8'h30, 0);
        wr(8'h00, 32'h1c0);
        cyc(3);
        rd(8'h2c, 0);
        cyc(5);
        end_of_test;
    end
endmodule // test_dsm_top
